// ===== logic/cdfc_pkg.sv
// Constants and carrier types of the demodulator and framing config block
// Contract
// RULE_01: Combine 01 holds stronger channel per communication
// RULE_02: Combine field acts only when fixed bit clear
// RULE_03: Fixed mode: low combine bit picks I or Q
// RULE_04: Receive PLL constant; 00 freezes PLL
// RULE_05: Separate PLL constant used during burst
// RULE_06: Response time is field plus seven bits
// RULE_07: Parity off stops parity generation and checking
// RULE_08: Parity off passes parity bit as data
// RULE_09: Start marker required: drop streams lacking it
// RULE_10: Start marker optional: accept, strip, never store
// RULE_11: End marker required: missing end flags error
// RULE_12: End marker optional: accept, strip, never store
// RULE_13: Length select picks maximum or minimum markers
// RULE_14: Suppress bits omit transmitted start/end markers
// RULE_15: Extra guard field gives zero to three bits
// RULE_16: Demodulator settings reset to 4D hex
// RULE_17: Reserved bits and registers ignore writes
package cdfc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_DEMOD = 8'h19;
   localparam logic [7:0] IDX_RSVD_A = 8'h1A;
   localparam logic [7:0] IDX_RSVD_B = 8'h1B;
   localparam logic [7:0] IDX_MFTX = 8'h1C;
   localparam logic [7:0] IDX_MFRX = 8'h1D;
   localparam logic [7:0] IDX_TYPEB = 8'h1E;
   localparam logic [7:0] IDX_STAT = 8'h30;
   localparam logic [7:0] IDX_MASK = 8'h31;
   localparam logic [7:0] RST_DEMOD = 8'h4D;
   localparam logic [7:0] RST_MFTX = 8'h62;
   localparam logic [7:0] RST_MFRX = 8'h00;
   localparam logic [7:0] RST_TYPEB = 8'h00;
   localparam logic [7:0] RST_RSVD = 8'h00;
   localparam logic [7:0] RST_IRQ = 8'h00;
   localparam logic [7:0] WM_DEMOD = 8'hEF;
   localparam logic [7:0] WM_MFTX = 8'h03;
   localparam logic [7:0] WM_MFRX = 8'h10;
   localparam logic [7:0] WM_TYPEB = 8'hDF;
   localparam logic [7:0] WM_IRQ = 8'h07;
   localparam int DM_COMB_LSB = 6;
   localparam int DM_FIX_BIT = 5;
   localparam int DM_TAUR_LSB = 2;
   localparam int DM_TAUS_LSB = 0;
   localparam int MT_WAIT_LSB = 0;
   localparam int MR_PAR_BIT = 4;
   localparam int TB_SOFREQ_BIT = 7;
   localparam int TB_EOFREQ_BIT = 6;
   localparam int TB_WIDTH_BIT = 4;
   localparam int TB_NOSOF_BIT = 3;
   localparam int TB_NOEOF_BIT = 2;
   localparam int TB_EGT_LSB = 0;
   localparam int IRQ_PROT_BIT = 0;
   localparam int IRQ_DISC_BIT = 1;
   localparam int IRQ_PAR_BIT = 2;
   localparam logic [1:0] COMB_HOLD = 2'h1;
   localparam logic [1:0] TAU_FROZEN = 2'h0;
   localparam logic [3:0] RESP_BASE_BITS = 4'h7;
   // Marker lengths in elementary time units
   localparam logic [3:0] MRK_LOW_MIN = 4'hA;
   localparam logic [3:0] MRK_LOW_MAX = 4'hB;
   localparam logic [1:0] MRK_HIGH_MIN = 2'h2;
   localparam logic [1:0] MRK_HIGH_MAX = 2'h3;

   typedef struct packed {
      logic [7:0] i_level;
      logic [7:0] q_level;
      logic comm_active;
      logic burst_phase;
   } cdfc_demod_in_s;
   typedef struct packed {
      logic use_q;
      logic pll_freeze;
      logic [1:0] pll_tau;
   } cdfc_demod_out_s;
   typedef struct packed {
      logic parity_gen;
      logic sof_en;
      logic eof_en;
      logic [3:0] marker_low_etu;
      logic [1:0] marker_high_etu;
      logic [1:0] egt_bits;
      logic [3:0] resp_wait_bits;
   } cdfc_tx_cfg_s;
   typedef struct packed {
      logic frame_start;
      logic sof_seen;
      logic byte_valid;
      logic [7:0] byte_data;
      logic parity_bit;
      logic frame_end;
      logic eof_seen;
   } cdfc_rx_in_s;
   typedef struct packed {
      logic wr;
      logic [8:0] data;
      logic parity_err;
      logic proto_err;
      logic discard;
   } cdfc_rx_out_s;
endpackage

// ===== logic/cdfc_rx_filter.sv
// Type B receive marker filter with parity handling
`timescale 1ns/100ps
module cdfc_rx_filter (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sof_req,
   input wire logic eof_req,
   input wire logic parity_off,
   input wire cdfc_pkg::cdfc_rx_in_s rx_in,
   output wire cdfc_pkg::cdfc_rx_out_s rx_out
);
   import cdfc_pkg::*;
   typedef enum logic [1:0] {ST_IDLE, ST_PASS, ST_DROP} cdfc_rxst_e;
   typedef struct packed {
      cdfc_rxst_e st;
      cdfc_rx_out_s o;
   } cdfc_filt_s;
   cdfc_filt_s cur_ff;
   cdfc_filt_s nxt_cur;

   assign rx_out = cur_ff.o;

   // Markers arrive as flags, never as bytes, so none reaches the FIFO
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.o = '0;
      case (cur_ff.st)
         ST_IDLE: begin
            if (rx_in.frame_start) begin
               if (sof_req && !rx_in.sof_seen) begin
                  nxt_cur.st = ST_DROP; // [RULE_09]
                  nxt_cur.o.discard = 1'b1;
               end else begin
                  nxt_cur.st = ST_PASS; // [RULE_10]
               end
            end
         end
         ST_PASS: begin
            if (rx_in.byte_valid) begin
               nxt_cur.o.wr = 1'b1;
               if (parity_off) begin
                  nxt_cur.o.data = // [RULE_08]
                     {rx_in.parity_bit, rx_in.byte_data};
               end else begin
                  nxt_cur.o.data = {1'b0, rx_in.byte_data};
                  nxt_cur.o.parity_err =
                     (~^rx_in.byte_data) != rx_in.parity_bit; // [RULE_07]
               end
            end
            if (rx_in.frame_end) begin
               nxt_cur.st = ST_IDLE;
               // A present end marker is consumed here [RULE_12]
               nxt_cur.o.proto_err = eof_req && !rx_in.eof_seen; // [RULE_11]
            end
         end
         ST_DROP: begin
            if (rx_in.frame_end) begin
               nxt_cur.st = ST_IDLE;
            end
         end
         default: begin
            nxt_cur.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_ff <= '{st: ST_IDLE, o: '0};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_no_sof;
      cur_ff.st == ST_IDLE && rx_in.frame_start && sof_req && !rx_in.sof_seen;
   endsequence
   property p_drop;
      s_no_sof |=> rx_out.discard && !rx_out.wr;
   endproperty
   a_drop: assert property (p_drop) // [RULE_09]
      else $error("missing start not dropped");
   property p_drop_quiet;
      cur_ff.st == ST_DROP |=> !rx_out.wr;
   endproperty
   a_drop_quiet: assert property (p_drop_quiet) // [RULE_09]
      else $error("dropped byte written");
   property p_accept;
      cur_ff.st == ST_IDLE && rx_in.frame_start && !sof_req
         |=> cur_ff.st == ST_PASS && !rx_out.discard;
   endproperty
   a_accept: assert property (p_accept) // [RULE_10]
      else $error("optional start refused");
   property p_eof_err;
      cur_ff.st == ST_PASS && rx_in.frame_end && eof_req && !rx_in.eof_seen
         |=> rx_out.proto_err;
   endproperty
   a_eof_err: assert property (p_eof_err) // [RULE_11]
      else $error("no protocol error");
   property p_eof_opt;
      !eof_req |=> !rx_out.proto_err;
   endproperty
   a_eof_opt: assert property (p_eof_opt) // [RULE_12]
      else $error("spurious protocol error");
   property p_par_data;
      cur_ff.st == ST_PASS && rx_in.byte_valid && parity_off
         |=> rx_out.wr && rx_out.data[8] == $past(rx_in.parity_bit)
             && !rx_out.parity_err;
   endproperty
   a_par_data: assert property (p_par_data) // [RULE_08]
      else $error("parity bit not data");
endmodule

// ===== logic/cdfc_top.sv
// APB register bank and control of the demodulator and framing config
`timescale 1ns/100ps
module cdfc_top (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output wire logic [31:0] prdata,
   output wire logic pready,
   output wire logic pslverr,
   input wire cdfc_pkg::cdfc_demod_in_s demod_in,
   input wire cdfc_pkg::cdfc_rx_in_s rx_in,
   output wire cdfc_pkg::cdfc_demod_out_s demod_out,
   output wire cdfc_pkg::cdfc_tx_cfg_s tx_cfg,
   output wire cdfc_pkg::cdfc_rx_out_s rx_out,
   output wire logic irq
);
   import cdfc_pkg::*;

   typedef struct packed {
      logic [7:0] demod;
      logic [7:0] mftx;
      logic [7:0] mfrx;
      logic [7:0] typeb;
      logic [7:0] stat;
      logic [7:0] mask;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic act_d;
      cdfc_demod_out_s dmo;
      cdfc_tx_cfg_s txc;
   } cdfc_top_s;

   cdfc_top_s top_ff;
   cdfc_top_s nxt_top;

   logic setup;
   logic access;
   logic wr_acc;
   logic [7:0] idx;
   logic aligned;
   logic [7:0] rd_val;
   logic rd_hit;
   logic [7:0] clr;
   logic [7:0] ev;
   logic [1:0] comb;
   logic fix;
   logic [1:0] tau_rx;
   logic [1:0] tau_burst;
   logic rx_phase;
   logic stronger_q;

   // Reserved bits keep their reset value whatever is written
   function automatic logic [7:0] wr_masked(
      input logic [7:0] old,
      input logic [7:0] data,
      input logic [7:0] wmask
   );
      wr_masked = (old & ~wmask) | (data & wmask);
   endfunction

   function automatic logic idx_is(
      input logic [7:0] a,
      input logic [7:0] b
   );
      idx_is = aligned && a == b;
   endfunction

   assign prdata = top_ff.prdata;
   assign pready = top_ff.pready;
   assign pslverr = top_ff.pslverr;
   assign irq = top_ff.irq;
   assign demod_out = top_ff.dmo;
   assign tx_cfg = top_ff.txc;

   assign setup = psel && !penable;
   assign access = psel && penable && top_ff.pready;
   assign wr_acc = access && pwrite && !top_ff.pslverr;
   assign idx = paddr[9:2];
   assign aligned = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0;

   assign comb = top_ff.demod[DM_COMB_LSB +: 2];
   assign fix = top_ff.demod[DM_FIX_BIT];
   assign tau_rx = top_ff.demod[DM_TAUR_LSB +: 2];
   assign tau_burst = top_ff.demod[DM_TAUS_LSB +: 2];
   assign rx_phase = demod_in.comm_active && !demod_in.burst_phase;
   assign stronger_q = demod_in.q_level > demod_in.i_level;

   assign ev = {5'h0, rx_out.parity_err, rx_out.discard, rx_out.proto_err};
   // Alignment spelled out: a function's hidden reads wake no assign
   assign clr = (wr_acc && aligned && idx == IDX_STAT) ?
                (pwdata[7:0] & WM_IRQ) : 8'h00;

   cdfc_rx_filter u_rx_filter (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .sof_req(top_ff.typeb[TB_SOFREQ_BIT]),
      .eof_req(top_ff.typeb[TB_EOFREQ_BIT]),
      .parity_off(top_ff.mfrx[MR_PAR_BIT]),
      .rx_in(rx_in),
      .rx_out(rx_out)
   );

   // Read mux; reserved registers answer with their reset value
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 8'h00;
      if (idx_is(idx, IDX_DEMOD)) begin
         rd_val = top_ff.demod;
      end else if (idx_is(idx, IDX_RSVD_A) || idx_is(idx, IDX_RSVD_B)) begin
         rd_val = RST_RSVD; // [RULE_17]
      end else if (idx_is(idx, IDX_MFTX)) begin
         rd_val = top_ff.mftx;
      end else if (idx_is(idx, IDX_MFRX)) begin
         rd_val = top_ff.mfrx;
      end else if (idx_is(idx, IDX_TYPEB)) begin
         rd_val = top_ff.typeb;
      end else if (idx_is(idx, IDX_STAT)) begin
         rd_val = top_ff.stat;
      end else if (idx_is(idx, IDX_MASK)) begin
         rd_val = top_ff.mask;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_comb begin
      nxt_top = top_ff;
      // One wait-free access phase per transfer
      nxt_top.pready = setup;
      if (setup) begin
         nxt_top.prdata = {24'h0, rd_val};
         nxt_top.pslverr = !rd_hit;
      end else if (!psel) begin
         nxt_top.pslverr = 1'b0;
      end
      if (wr_acc) begin
         if (idx_is(idx, IDX_DEMOD)) begin
            nxt_top.demod = wr_masked(top_ff.demod, pwdata[7:0], // [RULE_17]
               WM_DEMOD);
         end
         if (idx_is(idx, IDX_MFTX)) begin
            nxt_top.mftx = wr_masked(top_ff.mftx, pwdata[7:0], // [RULE_17]
               WM_MFTX);
         end
         if (idx_is(idx, IDX_MFRX)) begin
            nxt_top.mfrx = wr_masked(top_ff.mfrx, pwdata[7:0], // [RULE_17]
               WM_MFRX);
         end
         if (idx_is(idx, IDX_TYPEB)) begin
            nxt_top.typeb = wr_masked(top_ff.typeb, pwdata[7:0], // [RULE_17]
               WM_TYPEB);
         end
         if (idx_is(idx, IDX_MASK)) begin
            nxt_top.mask = pwdata[7:0] & WM_IRQ;
         end
      end
      // A new event beats a clear in the same cycle
      nxt_top.stat = (top_ff.stat & ~clr) | ev;
      nxt_top.irq = |(nxt_top.stat & nxt_top.mask);

      // Channel choice
      nxt_top.act_d = demod_in.comm_active;
      if (fix) begin
         nxt_top.dmo.use_q = comb[0]; // [RULE_02] [RULE_03]
      end else if (comb == COMB_HOLD && demod_in.comm_active) begin
         // Latch once at the start, then ignore level swings [RULE_01]
         if (!top_ff.act_d) begin
            nxt_top.dmo.use_q = stronger_q;
         end
      end else begin
         // Tracking; reserved codes behave as plain tracking
         nxt_top.dmo.use_q = stronger_q; // [RULE_02]
      end

      // PLL time constant per phase
      nxt_top.dmo.pll_tau = rx_phase ? // [RULE_04] [RULE_05]
         tau_rx : tau_burst;
      nxt_top.dmo.pll_freeze = rx_phase && tau_rx == TAU_FROZEN; // [RULE_04]

      // Transmit and framing configuration
      nxt_top.txc.resp_wait_bits = RESP_BASE_BITS +
         {2'h0, top_ff.mftx[MT_WAIT_LSB +: 2]}; // [RULE_06]
      nxt_top.txc.parity_gen = !top_ff.mfrx[MR_PAR_BIT]; // [RULE_07]
      nxt_top.txc.sof_en = !top_ff.typeb[TB_NOSOF_BIT]; // [RULE_14]
      nxt_top.txc.eof_en = !top_ff.typeb[TB_NOEOF_BIT]; // [RULE_14]
      nxt_top.txc.egt_bits = top_ff.typeb[TB_EGT_LSB +: 2]; // [RULE_15]
      if (top_ff.typeb[TB_WIDTH_BIT]) begin
         nxt_top.txc.marker_low_etu = MRK_LOW_MAX; // [RULE_13]
         nxt_top.txc.marker_high_etu = MRK_HIGH_MAX;
      end else begin
         nxt_top.txc.marker_low_etu = MRK_LOW_MIN; // [RULE_13]
         nxt_top.txc.marker_high_etu = MRK_HIGH_MIN;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         top_ff <= '0;
         top_ff.demod <= RST_DEMOD; // [RULE_16]
         top_ff.mftx <= RST_MFTX;
         top_ff.mfrx <= RST_MFRX;
         top_ff.typeb <= RST_TYPEB;
         top_ff.stat <= RST_IRQ;
         top_ff.mask <= RST_IRQ;
      end else begin
         top_ff <= nxt_top;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_rst_val;
      $rose(rst_n) |-> top_ff.demod == RST_DEMOD;
   endproperty
   a_rst_val: assert property (p_rst_val) // [RULE_16]
      else $error("bad demod reset");

   sequence s_hold_live;
      !fix && comb == COMB_HOLD && demod_in.comm_active && top_ff.act_d;
   endsequence
   property p_hold;
      s_hold_live |=> $stable(demod_out.use_q);
   endproperty
   a_hold: assert property (p_hold) // [RULE_01]
      else $error("channel moved mid frame");

   property p_track;
      !fix && comb != COMB_HOLD |=> demod_out.use_q == $past(stronger_q);
   endproperty
   a_track: assert property (p_track) // [RULE_02]
      else $error("not the stronger channel");

   property p_fixed;
      fix |=> demod_out.use_q == $past(comb[0]);
   endproperty
   a_fixed: assert property (p_fixed) // [RULE_03]
      else $error("fixed channel wrong");

   property p_freeze;
      rx_phase && tau_rx == TAU_FROZEN |=> demod_out.pll_freeze;
   endproperty
   a_freeze: assert property (p_freeze) // [RULE_04]
      else $error("PLL not frozen");

   property p_burst_tau;
      demod_in.burst_phase |=> demod_out.pll_tau == $past(tau_burst)
                               && !demod_out.pll_freeze;
   endproperty
   a_burst_tau: assert property (p_burst_tau) // [RULE_05]
      else $error("burst tau wrong");

   property p_resp;
      ##1 1'b1 |-> tx_cfg.resp_wait_bits
         == RESP_BASE_BITS + {2'h0, $past(top_ff.mftx[1:0])};
   endproperty
   a_resp: assert property (p_resp) // [RULE_06]
      else $error("response time wrong");

   property p_par_gen;
      top_ff.mfrx[MR_PAR_BIT] |=> !tx_cfg.parity_gen;
   endproperty
   a_par_gen: assert property (p_par_gen) // [RULE_07]
      else $error("parity still made");

   property p_width;
      top_ff.typeb[TB_WIDTH_BIT] |=> tx_cfg.marker_low_etu == MRK_LOW_MAX
                                     && tx_cfg.marker_high_etu == MRK_HIGH_MAX;
   endproperty
   a_width: assert property (p_width) // [RULE_13]
      else $error("marker length wrong");

   property p_suppress;
      top_ff.typeb[TB_NOSOF_BIT] && !top_ff.typeb[TB_NOEOF_BIT]
         |=> !tx_cfg.sof_en && tx_cfg.eof_en;
   endproperty
   a_suppress: assert property (p_suppress) // [RULE_14]
      else $error("marker suppress wrong");

   property p_egt;
      ##1 1'b1 |-> tx_cfg.egt_bits == $past(top_ff.typeb[1:0]);
   endproperty
   a_egt: assert property (p_egt) // [RULE_15]
      else $error("guard bits wrong");

   property p_rsvd;
      setup && !pwrite && idx_is(idx, IDX_RSVD_A)
         |=> prdata == 32'h0000_0000 && !pslverr;
   endproperty
   a_rsvd: assert property (p_rsvd) // [RULE_17]
      else $error("reserved reads nonzero");

   property p_ready_next;
      setup |=> pready;
   endproperty
   a_ready_next: assert property (p_ready_next)
      else $error("no ready after setup");

   property p_err_map;
      setup && !rd_hit |=> pslverr && prdata == 32'h0000_0000;
   endproperty
   a_err_map: assert property (p_err_map)
      else $error("unmapped access not refused");

   property p_err_keep;
      access && pslverr |=> $stable({top_ff.demod, top_ff.mftx,
                                     top_ff.mfrx, top_ff.typeb});
   endproperty
   a_err_keep: assert property (p_err_keep)
      else $error("refused write landed");

   property p_rsvd_b;
      setup && !pwrite && idx_is(idx, IDX_RSVD_B)
         |=> prdata == 32'h0000_0000 && !pslverr;
   endproperty
   a_rsvd_b: assert property (p_rsvd_b) // [RULE_17]
      else $error("reserved register B nonzero");

   property p_rsvd_bits;
      ((top_ff.demod ^ RST_DEMOD) & ~WM_DEMOD) == 8'h00
         && ((top_ff.mftx ^ RST_MFTX) & ~WM_MFTX) == 8'h00
         && ((top_ff.mfrx ^ RST_MFRX) & ~WM_MFRX) == 8'h00
         && ((top_ff.typeb ^ RST_TYPEB) & ~WM_TYPEB) == 8'h00;
   endproperty
   a_rsvd_bits: assert property (p_rsvd_bits) // [RULE_17]
      else $error("reserved bit changed");

   property p_set_wins;
      ev != 8'h00 |=> (top_ff.stat & $past(ev)) == $past(ev);
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost to clear");

   property p_irq_level;
      irq == |(top_ff.stat & top_ff.mask);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("irq disagrees with status");

   sequence s_hold_start;
      !fix && comb == COMB_HOLD && demod_in.comm_active && !top_ff.act_d;
   endsequence
   property p_latch;
      s_hold_start |=> demod_out.use_q == $past(stronger_q);
   endproperty
   a_latch: assert property (p_latch) // [RULE_01]
      else $error("stronger channel not latched");

   property p_rx_tau;
      rx_phase |=> demod_out.pll_tau == $past(tau_rx);
   endproperty
   a_rx_tau: assert property (p_rx_tau) // [RULE_04]
      else $error("receive tau wrong");
endmodule

// ===== logic/cdfc_unused_guard.sv
// Holds no logic; every module lives in the other design files

// ===== verif/cdfc_card_model.sv
// Card-side model that feeds decoded type B frames into the filter
`timescale 1ns/100ps
module cdfc_card_model (
   input wire logic ref_clk,
   output cdfc_pkg::cdfc_rx_in_s rx_in
);
   import cdfc_pkg::*;
   initial rx_in = '0;
   // Markers ride as flags beside the frame edges, as the framer shows them
   // Unqualified fields flip so a stale value can never pass for a fresh one
   task automatic frame(input logic s, input logic e, input logic [7:0] b,
         input logic p);
      @(posedge ref_clk);
      rx_in.frame_start <= 1'b1;
      rx_in.sof_seen <= s;
      @(posedge ref_clk);
      rx_in.frame_start <= 1'b0;
      rx_in.sof_seen <= ~s;
      rx_in.byte_valid <= 1'b1;
      rx_in.byte_data <= b;
      rx_in.parity_bit <= p;
      @(posedge ref_clk);
      rx_in.byte_valid <= 1'b0;
      rx_in.byte_data <= ~b;
      rx_in.parity_bit <= ~p;
      rx_in.frame_end <= 1'b1;
      rx_in.eof_seen <= e;
      @(posedge ref_clk);
      rx_in.frame_end <= 1'b0;
      rx_in.eof_seen <= ~e;
   endtask
endmodule

// ===== verif/test_cdfc_top.sv
// Self-checking bench for the demodulator and framing config block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_cdfc_top;
   import cdfc_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   wire logic [31:0] prdata;
   wire logic pready;
   wire logic pslverr;
   wire logic irq;
   cdfc_demod_in_s demod_in = '0;
   wire cdfc_rx_in_s rx_in;
   wire cdfc_demod_out_s demod_out;
   wire cdfc_tx_cfg_s tx_cfg;
   wire cdfc_rx_out_s rx_out;
   int fails = 0;
   int n_checks = 0;
   int n_wr, n_perr, n_proto, n_disc, k;
   logic [8:0] last_data;
   logic [31:0] rd;
   logic er;
   logic [11:0] ra [4] = '{12'h064, 12'h070, 12'h074, 12'h078};
   logic [7:0] wm [4] = '{WM_DEMOD, WM_MFTX, WM_MFRX, WM_TYPEB};
   logic [7:0] rv [4] = '{RST_DEMOD, RST_MFTX, RST_MFRX, RST_TYPEB};

   always #2.5 ref_clk = ~ref_clk;
   cdfc_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .demod_in(demod_in), .rx_in(rx_in), .demod_out(demod_out),
      .tx_cfg(tx_cfg), .rx_out(rx_out), .irq(irq));
   cdfc_card_model card (.ref_clk(ref_clk), .rx_in(rx_in));

   // Filter outputs are one-cycle pulses, so they are counted, not polled
   always @(posedge ref_clk) begin
      if (rx_out.wr === 1'b1) begin
         n_wr++;
         last_data = rx_out.data;
      end
      n_perr += (rx_out.parity_err === 1'b1);
      n_proto += (rx_out.proto_err === 1'b1);
      n_disc += (rx_out.discard === 1'b1);
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (pready !== 1'b1 && i < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fails++;
         $display("[ERR] pready exp 1 got %b", pready);
         close_out();
      end
   endtask

   task automatic settle();
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   task automatic chk_rd(input string nm, input logic [11:0] a,
         input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(nm, {24'h0, e}, rd)
   endtask

   task automatic dchk(input string nm, input logic [7:0] v,
         input logic qs, input logic ca, input logic bp, input logic [3:0] e);
      apb(1'b1, 12'h064, {24'h0, v});
      demod_in <= '{i_level: qs ? 8'h40 : 8'h80,
         q_level: qs ? 8'h80 : 8'h40, comm_active: ca, burst_phase: bp};
      settle();
      `CHK(nm, e, demod_out)
   endtask

   task automatic rxf(input logic s, input logic e, input logic [7:0] b,
         input logic p);
      n_wr = 0;
      n_perr = 0;
      n_proto = 0;
      n_disc = 0;
      card.frame(s, e, b, p);
      repeat (3) @(posedge ref_clk);
   endtask

   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      settle();
      chk_rd("demod", 12'h064, RST_DEMOD);
      chk_rd("mftx", 12'h070, RST_MFTX);
      chk_rd("mfrx", 12'h074, RST_MFRX);
      chk_rd("typeb", 12'h078, RST_TYPEB);
      chk_rd("rsvd_b", 12'h06C, RST_RSVD);
      `CHK("tau_rst", RST_DEMOD[1:0], demod_out.pll_tau)
      `CHK("wait_rst", 4'h9, tx_cfg.resp_wait_bits)
      $display("test reset done");
      // Reserved bits must survive both all-ones and all-zeros writes
      for (k = 0; k < 4; k++) begin
         apb(1'b1, ra[k], 32'hFFFF_FFFF);
         chk_rd("wr_ones", ra[k], wm[k] | (rv[k] & ~wm[k]));
         apb(1'b1, ra[k], 32'h0);
         chk_rd("wr_zeros", ra[k], rv[k] & ~wm[k]);
      end
      apb(1'b1, 12'h068, 32'hFF);
      chk_rd("rsvd_a", 12'h068, RST_RSVD);
      apb(0, 12'h100, 32'h0);
      `CHK("err_unmapped", 1'b1, er)
      `CHK("rd_unmapped", 32'h0, rd)
      apb(1'b1, 12'h065, 32'hFF);
      `CHK("err_unaligned", 1'b1, er)
      chk_rd("demod_kept", 12'h064, 8'h00);
      $display("test access done");
      for (k = 0; k < 4; k++) begin
         apb(1'b1, 12'h070, {30'h0, k[1:0]});
         apb(1'b1, 12'h078, {27'h0, k[0], k[1], ~k[1], k[1], k[0]});
         settle();
         `CHK("wait", 4'h7 + {2'h0, k[1:0]}, tx_cfg.resp_wait_bits)
         `CHK("egt", k[1:0], tx_cfg.egt_bits)
         `CHK("mlow", k[0] ? MRK_LOW_MAX : MRK_LOW_MIN, tx_cfg.marker_low_etu)
         `CHK("mhigh", k[0] ? MRK_HIGH_MAX : MRK_HIGH_MIN, tx_cfg.marker_high_etu)
         `CHK("sof_en", ~k[1], tx_cfg.sof_en)
         `CHK("eof_en", k[1], tx_cfg.eof_en)
      end
      apb(1'b1, 12'h074, 32'h10);
      settle();
      `CHK("par_gen", 1'b0, tx_cfg.parity_gen)
      $display("test tx done");
      dchk("fix_i", 8'h20, 1, 0, 0, 4'b0000);
      dchk("fix_q", 8'h60, 0, 0, 0, 4'b1000);
      dchk("track_q", 8'h00, 1, 0, 0, 4'b1000);
      dchk("track_i", 8'h00, 0, 0, 0, 4'b0000);
      dchk("freeze", 8'h01, 0, 1, 0, 4'b0100);
      dchk("burst", 8'h01, 0, 1, 1, 4'b0001);
      dchk("rx_tau", 8'h09, 0, 1, 0, 4'b0010);
      dchk("idle", 8'h00, 0, 0, 0, 4'b0000);
      dchk("hold_a", 8'h40, 1, 1, 0, 4'b1100);
      dchk("hold_b", 8'h40, 0, 1, 0, 4'b1100);
      $display("test demod done");
      rxf(0, 0, 8'hA5, 1);
      `CHK("wr_nosof", 1, n_wr)
      `CHK("data_par", 9'h1A5, last_data)
      `CHK("perr_off", 0, n_perr)
      apb(1'b1, 12'h074, 32'h0);
      rxf(1, 1, 8'hA5, 0);
      `CHK("perr_on", 1, n_perr)
      `CHK("data_nopar", 9'h0A5, last_data)
      `CHK("par_gen_on", 1'b1, tx_cfg.parity_gen)
      apb(1'b1, 12'h0C0, 32'hFF);
      apb(1'b1, 12'h078, 32'hC0);
      rxf(0, 1, 8'h3C, 1);
      `CHK("disc", 1, n_disc)
      `CHK("wr_disc", 0, n_wr)
      rxf(1, 0, 8'h3C, 1);
      `CHK("proto", 1, n_proto)
      `CHK("wr_proto", 1, n_wr)
      apb(1'b1, 12'h078, 32'h0);
      rxf(1, 0, 8'h3C, 1);
      `CHK("proto_opt", 0, n_proto)
      `CHK("wr_opt", 1, n_wr)
      $display("test rx done");
      chk_rd("status", 12'h0C0, 8'h03);
      `CHK("irq_masked", 1'b0, irq)
      apb(1'b1, 12'h0C4, 32'h1);
      settle();
      `CHK("irq_on", 1'b1, irq)
      apb(1'b1, 12'h0C0, 32'h1);
      settle();
      `CHK("irq_off", 1'b0, irq)
      chk_rd("status_clr", 12'h0C0, 8'h02);
      $display("test irq done");
      close_out();
   end
endmodule
